//--- src/bcd_cmp.sv
// Decimal magnitude compare
`timescale 1ns/100ps
module bcd_cmp
	import bcd_pkg::*;
(
	input bcd_val_t a_in,
	input bcd_val_t b_in,
	output logic gt_out,
	output logic lt_out
);
	// Packed decimal orders like binary when digits are valid
	always_comb begin
		gt_out = a_in > b_in;
		lt_out = a_in < b_in;
	end
endmodule : bcd_cmp

//--- src/bcd_counter_unit.sv
// Decimal reversible counter unit with APB registers
`timescale 1ns/100ps
`include "bcd_defines.svh"
module bcd_counter_unit
	import bcd_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic count1_in,
	input wire logic count2_in,
	input wire logic ext_clear_in,
	output logic coin_out,
	output logic greater_out
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] ctrl; // Control bits
		bcd_val_t preset; // Preset digits
		bcd_val_t cmpv; // Compare value
		bcd_val_t cnt; // Present count
		logic [1:0] mode; // Input mode
		logic carry, borrow, eq;
		logic c_arm, b_arm, e_arm; // Rearm after a clear
		logic [31:0] rdata;
		logic coin, greater;
	} bcd_top_s;
	bcd_top_s st_q, st_d;
	bcd_step_s step;
	logic gt, lt, wr, rd;
	bcd_val_t nxt;
	// One decimal step in either direction
	function automatic bcd_val_t bcd_step(input bcd_val_t v, input logic up);
		bcd_val_t r;
		logic go;
		r = v;
		go = 1'b1;
		// Ripple from the lowest digit until one digit absorbs the step
		for (int i = 0; i < `BCD_DIGITS; i++) begin
			if (go) begin
				if (up) begin
					if (v[i*`BCD_DIG_W +: `BCD_DIG_W] == `BCD_DIG_NINE) begin
						r[i*`BCD_DIG_W +: `BCD_DIG_W] = `BCD_DIG_ZERO;
					end else begin
						r[i*`BCD_DIG_W +: `BCD_DIG_W] = v[i*`BCD_DIG_W +: `BCD_DIG_W] + `BCD_DIG_ONE;
						go = 1'b0;
					end
				end else begin
					if (v[i*`BCD_DIG_W +: `BCD_DIG_W] == `BCD_DIG_ZERO) begin
						r[i*`BCD_DIG_W +: `BCD_DIG_W] = `BCD_DIG_NINE;
					end else begin
						r[i*`BCD_DIG_W +: `BCD_DIG_W] = v[i*`BCD_DIG_W +: `BCD_DIG_W] - `BCD_DIG_ONE;
						go = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction : bcd_step
	// ==========================================================
	// Input decoder and comparator
	bcd_edge u_edge (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.in1_in(count1_in),
		.in2_in(count2_in),
		.mode_in(st_q.mode),
		.down_in(st_q.ctrl[`BCD_B_DOWN]),
		.step_out(step)
	);
	bcd_cmp u_cmp (
		.a_in(st_q.cnt),
		.b_in(st_q.cmpv),
		.gt_out(gt),
		.lt_out(lt)
	);
	assign pready_out = 1'b1;
	assign pslverr_out = 1'b0;
	assign prdata_out = st_q.rdata;
	assign coin_out = st_q.coin;
	assign greater_out = st_q.greater;
	// ==========================================================
	// Next state
	always_comb begin
		logic cnt_ev;
		cnt_ev = 1'b0;
		st_d = st_q;
		wr = psel_in & penable_in & pwrite_in;
		rd = psel_in & penable_in & ~pwrite_in;
		nxt = bcd_step(st_q.cnt, step.up);
		// Register writes
		if (wr) begin
			if (paddr_in == `BCD_ADDR_CTRL) begin
				st_d.ctrl = pwdata_in[7:0];
				st_d.preset[7:0] = pwdata_in[15:8];
			end else if (paddr_in == `BCD_ADDR_PRE_HI) begin
				st_d.preset[23:8] = pwdata_in[15:0];
			end else if (paddr_in == `BCD_ADDR_MODE) begin
				st_d.mode = pwdata_in[1:0];
			end
		end
		// Gated counting
		if (st_q.ctrl[`BCD_B_GATE] && step.inc) begin
			st_d.cnt = nxt;
			cnt_ev = 1'b1;
			st_d.c_arm = 1'b1;
			st_d.b_arm = 1'b1;
			st_d.e_arm = 1'b1;
			// A rollover is itself a count, so it needs no prior arming
			if (step.up && st_q.cnt == `BCD_MAX) begin
				st_d.carry = 1'b1;
			end
			if (!step.up && st_q.cnt == `BCD_ZERO) begin
				st_d.borrow = 1'b1;
			end
		end
		// Loads take priority over a count in the same cycle
		if (st_q.ctrl[`BCD_B_LOAD]) begin
			st_d.cnt = st_q.preset;
		end
		if (st_q.ctrl[`BCD_B_CMPLD]) begin
			st_d.cmpv = st_q.preset;
		end
		// Equality latches while armed
		if (st_q.cnt == st_q.cmpv && st_q.e_arm) begin
			st_d.eq = 1'b1;
		end
		// Clears; a counting event in the same cycle still sets
		if ((st_q.ctrl[`BCD_B_CCLR] || ext_clear_in) && !cnt_ev) begin
			st_d.carry = 1'b0;
			st_d.c_arm = 1'b0;
		end
		if ((st_q.ctrl[`BCD_B_BCLR] || ext_clear_in) && !cnt_ev) begin
			st_d.borrow = 1'b0;
			st_d.b_arm = 1'b0;
		end
		if ((st_q.ctrl[`BCD_B_ECLR] || ext_clear_in) && !cnt_ev) begin
			st_d.eq = 1'b0;
			st_d.e_arm = 1'b0;
		end
		// External outputs gated by output enable
		st_d.coin = st_q.eq & st_q.ctrl[`BCD_B_OE];
		st_d.greater = gt & st_q.ctrl[`BCD_B_OE];
		// Read data
		st_d.rdata = '0;
		if (psel_in && !penable_in && !pwrite_in) begin
			if (paddr_in == `BCD_ADDR_CTRL) begin
				st_d.rdata[15:0] = {st_q.preset[7:0], st_q.ctrl};
			end else if (paddr_in == `BCD_ADDR_PRE_HI) begin
				st_d.rdata[15:0] = st_q.preset[23:8];
			end else if (paddr_in == `BCD_ADDR_STAT) begin
				st_d.rdata[15:0] = {st_q.cnt[7:0], `BCD_STAT_ONES, lt, st_q.eq, gt,
					st_q.borrow, st_q.carry};
			end else if (paddr_in == `BCD_ADDR_CNT_HI) begin
				st_d.rdata[15:0] = st_q.cnt[23:8];
			end else if (paddr_in == `BCD_ADDR_MODE) begin
				st_d.rdata[1:0] = st_q.mode;
			end
		end else if (rd) begin
			st_d.rdata = st_q.rdata;
		end
	end
	// ==========================================================
	// Registers
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	// ==========================================================
	// Checks
	property p_carry_up;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.ctrl[`BCD_B_GATE] && step.inc && step.up && st_q.cnt == `BCD_MAX)
		|=> st_q.carry && (st_q.cnt == `BCD_ZERO || $past(st_q.ctrl[`BCD_B_LOAD]));
	endproperty
	a_carry_up: assert property (p_carry_up) else $error("carry missed");
	property p_borrow;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.ctrl[`BCD_B_GATE] && step.inc && !step.up && st_q.cnt == `BCD_ZERO)
		|=> st_q.borrow && (st_q.cnt == `BCD_MAX || $past(st_q.ctrl[`BCD_B_LOAD]));
	endproperty
	a_borrow: assert property (p_borrow) else $error("borrow missed");
	property p_gate;
		@(posedge mclk_in) disable iff (reset_in)
		(!st_q.ctrl[`BCD_B_GATE] && !st_q.ctrl[`BCD_B_LOAD]) |=> $stable(st_q.cnt);
	endproperty
	a_gate: assert property (p_gate) else $error("count moved with gate off");
	property p_load;
		@(posedge mclk_in) disable iff (reset_in)
		st_q.ctrl[`BCD_B_LOAD] |=> st_q.cnt == $past(st_q.preset);
	endproperty
	a_load: assert property (p_load) else $error("load failed");
	property p_cmpld;
		@(posedge mclk_in) disable iff (reset_in)
		st_q.ctrl[`BCD_B_CMPLD] |=> st_q.cmpv == $past(st_q.preset);
	endproperty
	a_cmpld: assert property (p_cmpld) else $error("compare load failed");
	property p_oe;
		@(posedge mclk_in) disable iff (reset_in)
		!st_q.ctrl[`BCD_B_OE] |=> !coin_out && !greater_out;
	endproperty
	a_oe: assert property (p_oe) else $error("output without enable");
	property p_eqclr;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.ctrl[`BCD_B_ECLR] && !(st_q.ctrl[`BCD_B_GATE] && step.inc)) |=> !st_q.eq;
	endproperty
	a_eqclr: assert property (p_eqclr) else $error("equality not cleared");
	property p_cmp;
		@(posedge mclk_in) disable iff (reset_in)
		!(gt && lt) && ((gt || lt) != (st_q.cnt == st_q.cmpv));
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare wrong");
	c_carry: cover property (@(posedge mclk_in) disable iff (reset_in) $rose(st_q.carry));
	c_borrow: cover property (@(posedge mclk_in) disable iff (reset_in) $rose(st_q.borrow));
	c_coin: cover property (@(posedge mclk_in) disable iff (reset_in) $rose(coin_out));
	// Clearing carry without a count drops it
	property p_carry_clr;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.ctrl[`BCD_B_CCLR] && !(st_q.ctrl[`BCD_B_GATE] && step.inc)) |=> !st_q.carry;
	endproperty
	a_carry_clr: assert property (p_carry_clr) else $error("carry not cleared");
	// Clearing borrow without a count drops it
	property p_borrow_clr;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.ctrl[`BCD_B_BCLR] && !(st_q.ctrl[`BCD_B_GATE] && step.inc)) |=> !st_q.borrow;
	endproperty
	a_borrow_clr: assert property (p_borrow_clr) else $error("borrow not cleared");
	// A set carry was always preceded by a count since the last clear
	property p_carry_arm;
		@(posedge mclk_in) disable iff (reset_in)
		st_q.carry |-> st_q.c_arm;
	endproperty
	a_carry_arm: assert property (p_carry_arm) else $error("carry without count");
	// A set borrow was always preceded by a count since the last clear
	property p_borrow_arm;
		@(posedge mclk_in) disable iff (reset_in)
		st_q.borrow |-> st_q.b_arm;
	endproperty
	a_borrow_arm: assert property (p_borrow_arm) else $error("borrow without count");
	// Carry latches until a clear
	property p_carry_hold;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.carry && !st_q.ctrl[`BCD_B_CCLR] && !ext_clear_in) |=> st_q.carry;
	endproperty
	a_carry_hold: assert property (p_carry_hold) else $error("carry dropped");
	// Borrow latches until a clear
	property p_borrow_hold;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.borrow && !st_q.ctrl[`BCD_B_BCLR] && !ext_clear_in) |=> st_q.borrow;
	endproperty
	a_borrow_hold: assert property (p_borrow_hold) else $error("borrow dropped");
	// Equality latches until a clear
	property p_eq_hold;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.eq && !st_q.ctrl[`BCD_B_ECLR] && !ext_clear_in) |=> st_q.eq;
	endproperty
	a_eq_hold: assert property (p_eq_hold) else $error("equality dropped");
	// Disarmed equality stays off until a count
	property p_eq_rearm;
		@(posedge mclk_in) disable iff (reset_in)
		(!st_q.eq && !st_q.e_arm && !(st_q.ctrl[`BCD_B_GATE] && step.inc)) |=> !st_q.eq;
	endproperty
	a_eq_rearm: assert property (p_eq_rearm) else $error("equality set without count");
	// External clear drops every latched flag
	property p_ext_clear;
		@(posedge mclk_in) disable iff (reset_in)
		(ext_clear_in && !(st_q.ctrl[`BCD_B_GATE] && step.inc))
		|=> !st_q.carry && !st_q.borrow && !st_q.eq;
	endproperty
	a_ext_clear: assert property (p_ext_clear) else $error("external clear failed");
	// Coincidence reaches the pin when enabled
	property p_coin_out;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.ctrl[`BCD_B_OE] && st_q.eq) |=> coin_out;
	endproperty
	a_coin_out: assert property (p_coin_out) else $error("coincidence not driven");
	// Greater-than reaches the pin when enabled
	property p_gt_out;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.ctrl[`BCD_B_OE] && gt) |=> greater_out;
	endproperty
	a_gt_out: assert property (p_gt_out) else $error("greater not driven");
	// Program mode direction follows the control bit
	property p_up_step;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.mode == `BCD_MODE_PROG && step.inc) |-> step.up == !st_q.ctrl[`BCD_B_DOWN];
	endproperty
	a_up_step: assert property (p_up_step) else $error("wrong direction");
	// A gated count without a load in the same cycle always moves the value
	property p_gate_count;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.ctrl[`BCD_B_GATE] && step.inc && !st_q.ctrl[`BCD_B_LOAD]) |=> !$stable(st_q.cnt);
	endproperty
	a_gate_count: assert property (p_gate_count) else $error("gated count lost");
	// Zero count below a nonzero compare reads less
	property p_lt_zero;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.cnt == `BCD_ZERO && st_q.cmpv != `BCD_ZERO) |-> lt;
	endproperty
	a_lt_zero: assert property (p_lt_zero) else $error("less missing");
	// Full count above a smaller compare reads greater
	property p_gt_max;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.cnt == `BCD_MAX && st_q.cmpv != `BCD_MAX) |-> gt;
	endproperty
	a_gt_max: assert property (p_gt_max) else $error("greater missing");
	// Lowest digit steps up by one without carry
	property p_up_value;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.ctrl[`BCD_B_GATE] && step.inc && step.up && !st_q.ctrl[`BCD_B_LOAD]
			&& st_q.cnt[3:0] != `BCD_DIG_NINE)
		|=> st_q.cnt[3:0] == $past(st_q.cnt[3:0]) + `BCD_DIG_ONE;
	endproperty
	a_up_value: assert property (p_up_value) else $error("up step wrong");
	// Lowest digit steps down by one without borrow
	property p_down_value;
		@(posedge mclk_in) disable iff (reset_in)
		(st_q.ctrl[`BCD_B_GATE] && step.inc && !step.up && !st_q.ctrl[`BCD_B_LOAD]
			&& st_q.cnt[3:0] != `BCD_DIG_ZERO)
		|=> st_q.cnt[3:0] == $past(st_q.cnt[3:0]) - `BCD_DIG_ONE;
	endproperty
	a_down_value: assert property (p_down_value) else $error("down step wrong");
	// Control write lands in the access cycle
	property p_ctrl_write;
		@(posedge mclk_in) disable iff (reset_in)
		(psel_in && penable_in && pwrite_in && paddr_in == `BCD_ADDR_CTRL)
		|=> st_q.ctrl == $past(pwdata_in[7:0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
	// High preset write lands in the access cycle
	property p_preset_hi;
		@(posedge mclk_in) disable iff (reset_in)
		(psel_in && penable_in && pwrite_in && paddr_in == `BCD_ADDR_PRE_HI)
		|=> st_q.preset[23:8] == $past(pwdata_in[15:0]);
	endproperty
	a_preset_hi: assert property (p_preset_hi) else $error("preset write lost");
	// Cover points
	c_eq: cover property (@(posedge mclk_in) disable iff (reset_in) $rose(st_q.eq));
	c_quad_down: cover property (@(posedge mclk_in) disable iff (reset_in)
		st_q.mode == `BCD_MODE_QUAD && step.inc && !step.up);
endmodule : bcd_counter_unit

//--- src/bcd_defines.svh
// Constants of the decimal reversible counter unit
`ifndef BCD_DEFINES_SVH
`define BCD_DEFINES_SVH
// ==========================================================
// Register byte addresses
`define BCD_ADDR_CTRL 12'h000
`define BCD_ADDR_PRE_HI 12'h004
`define BCD_ADDR_STAT 12'h008
`define BCD_ADDR_CNT_HI 12'h00c
`define BCD_ADDR_MODE 12'h010
// ==========================================================
// Control bit positions
`define BCD_B_LOAD 0
`define BCD_B_CMPLD 1
`define BCD_B_GATE 2
`define BCD_B_DOWN 3
`define BCD_B_CCLR 4
`define BCD_B_BCLR 5
`define BCD_B_ECLR 6
`define BCD_B_OE 7
// ==========================================================
// Values
`define BCD_MAX 24'h999999
`define BCD_ZERO 24'h000000
`define BCD_STAT_ONES 3'h7
`define BCD_DIGITS 6
`define BCD_DIG_W 4
`define BCD_DIG_NINE 4'h9
`define BCD_DIG_ZERO 4'h0
`define BCD_DIG_ONE 4'h1
`define BCD_MODE_PROG 2'h0
`define BCD_MODE_PIN 2'h1
`define BCD_MODE_QUAD 2'h2
`endif

//--- src/bcd_edge.sv
// Input synchroniser and count decoder
`timescale 1ns/100ps
`include "bcd_defines.svh"
module bcd_edge
	import bcd_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic in1_in,
	input wire logic in2_in,
	input wire logic [1:0] mode_in,
	input wire logic down_in,
	output bcd_step_s step_out
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [1:0] s1; // First stage, read only by second
		logic [1:0] s2; // Second stage
		logic [1:0] s3; // Previous sample for edges
		logic up_at_rise; // Direction seen at last input one rise
	} bcd_edge_s;
	bcd_edge_s st_q, st_d;
	logic rise1, fall1;
	always_comb begin
		st_d = st_q;
		st_d.s1 = {in2_in, in1_in};
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		rise1 = st_q.s2[0] & ~st_q.s3[0];
		fall1 = ~st_q.s2[0] & st_q.s3[0];
		step_out = '0;
		// Quadrature: input two low at rise means input one leads
		if (rise1) begin
			st_d.up_at_rise = ~st_q.s2[1];
		end
		if (mode_in == `BCD_MODE_PROG) begin
			step_out.inc = rise1;
			step_out.up = ~down_in;
		end else if (mode_in == `BCD_MODE_PIN) begin
			step_out.inc = rise1;
			step_out.up = st_q.s2[1];
		end else begin
			// Down at rise when lagging, up at fall when leading
			step_out.inc = (rise1 & st_q.s2[1]) | (fall1 & st_q.up_at_rise);
			step_out.up = fall1;
		end
	end
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : bcd_edge

//--- src/bcd_pkg.sv
// Types of the decimal reversible counter unit
package bcd_pkg;
	typedef logic [23:0] bcd_val_t; // Six packed decimal digits
	typedef enum logic [1:0] {BCD_PROG, BCD_PIN, BCD_QUAD} bcd_mode_e;
	typedef struct packed {
		logic inc; // Count one step
		logic up; // Direction of that step
	} bcd_step_s;
	typedef struct packed {
		logic carry;
		logic borrow;
		logic gt;
		logic eq;
		logic lt;
	} bcd_flags_s;
endpackage : bcd_pkg

//--- tb/bcd_counter_unit_tb.sv
// Self-checking bench of the decimal counter unit
`timescale 1ns/100ps
`include "bcd_defines.svh"
module bcd_counter_unit_tb;
	// ==========================================================
	// Signals
	logic mclk_in, reset_in, psel, pen, pwr, go, lvl, xclr;
	logic [11:0] pa;
	logic [31:0] pwd, prd;
	logic prdy, perr, c1, c2, coin, gtr;
	logic [1:0] kind;
	int error_cnt, comparisons;
	initial begin
		mclk_in = 1'h0;
		forever #50 mclk_in = ~mclk_in;
	end
	bcd_counter_unit bcd_counter_unit_inst (.mclk_in(mclk_in), .reset_in(reset_in),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
		.pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
		.count1_in(c1), .count2_in(c2), .ext_clear_in(xclr), .coin_out(coin),
		.greater_out(gtr));
	bcd_pulse_model bcd_pulse_model_inst (.clk_in(mclk_in), .go_in(go), .kind_in(kind),
		.lvl_in(lvl), .c1_out(c1), .c2_out(c2));
	// ==========================================================
	// Tasks
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask : chk
	// One APB transfer, held until pready is seen
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge mclk_in);
		psel <= 1'h1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge mclk_in);
		pen <= 1'h1;
		do @(posedge mclk_in); while (prdy !== 1'h1);
		r = prd;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask : acc
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		acc(1'h1, a, d, r);
	endtask : wr
	task rd(input string n, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		acc(1'h0, a, 32'h0, r);
		chk(n, e, r);
	endtask : rd
	// Fixed wait covers sync, edge and count latency
	task pulse(input logic [1:0] k);
		@(posedge mclk_in);
		go <= 1'h1;
		kind <= k;
		@(posedge mclk_in);
		go <= 1'h0;
		repeat (24) @(posedge mclk_in);
	endtask : pulse
	task wrap_up;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	// ==========================================================
	// Watchdog, well above the few hundred cycles needed
	initial begin
		repeat (3000) @(posedge mclk_in);
		error_cnt++;
		wrap_up;
	end
	// ==========================================================
	// Tests
	initial begin
		{psel, pen, pwr, go, lvl, xclr, pa, pwd, kind} = '0;
		error_cnt = 0;
		comparisons = 0;
		reset_in = 1'h1;
		repeat (12) @(posedge mclk_in);
		reset_in <= 1'h0;
		rd("stat", `BCD_ADDR_STAT, 32'he0);
		chk("coin", 32'h0, coin);
		wr(`BCD_ADDR_PRE_HI, 32'h9999);
		wr(`BCD_ADDR_CTRL, 32'h9801);
		wr(`BCD_ADDR_CTRL, 32'h9800);
		rd("stat", `BCD_ADDR_STAT, 32'h98e4);
		rd("count_hi", `BCD_ADDR_CNT_HI, 32'h9999);
		wr(`BCD_ADDR_CTRL, 32'h9804);
		repeat (2) pulse(2'h0);
		rd("stat", `BCD_ADDR_STAT, 32'he9);
		wr(`BCD_ADDR_CTRL, 32'h9854);
		wr(`BCD_ADDR_CTRL, 32'h9804);
		rd("stat", `BCD_ADDR_STAT, 32'he0);
		wr(`BCD_ADDR_CTRL, 32'h988c);
		pulse(2'h0);
		rd("stat", `BCD_ADDR_STAT, 32'h99e6);
		chk("greater", 32'h1, gtr);
		wr(`BCD_ADDR_CTRL, 32'h9888);
		pulse(2'h0);
		rd("stat", `BCD_ADDR_STAT, 32'h99e6);
		wr(`BCD_ADDR_CTRL, 32'h988e);
		wr(`BCD_ADDR_CTRL, 32'h988c);
		pulse(2'h0);
		rd("stat", `BCD_ADDR_STAT, 32'h98ea);
		chk("coin", 32'h1, coin);
		pulse(2'h0);
		rd("stat", `BCD_ADDR_STAT, 32'h97fa);
		wr(`BCD_ADDR_MODE, 32'h1);
		lvl <= 1'h1;
		pulse(2'h0);
		rd("stat", `BCD_ADDR_STAT, 32'h98ea);
		lvl <= 1'h0;
		pulse(2'h0);
		rd("stat", `BCD_ADDR_STAT, 32'h97fa);
		wr(`BCD_ADDR_MODE, 32'h2);
		pulse(2'h1);
		rd("stat", `BCD_ADDR_STAT, 32'h98ea);
		pulse(2'h2);
		rd("stat", `BCD_ADDR_STAT, 32'h97fa);
		@(posedge mclk_in);
		xclr <= 1'h1;
		@(posedge mclk_in);
		xclr <= 1'h0;
		repeat (4) @(posedge mclk_in);
		rd("stat", `BCD_ADDR_STAT, 32'h97f0);
		chk("coin", 32'h0, coin);
		rd("unmapped", 12'h014, 32'h0);
		wrap_up;
	end
endmodule : bcd_counter_unit_tb

//--- tb/bcd_pulse_model.sv
// Count input source standing in for the sensor side
`timescale 1ns/100ps
module bcd_pulse_model (
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [1:0] kind_in,
	input wire logic lvl_in,
	output logic c1_out,
	output logic c2_out
);
	// ==========================================================
	// Frame timing
	logic [4:0] cnt_q = 5'h00; // Frame position, zero when idle
	logic [4:0] pos;
	logic [1:0] ph; // Quarter of the frame
	logic act;
	logic lead;
	logic lag;
	assign act = cnt_q != 5'h00;
	assign pos = cnt_q - 5'h01;
	assign ph = pos[3:2];
	// Quarters of four cycles, so the synchroniser sees every level
	always @(posedge clk_in) begin
		if (go_in)
			cnt_q <= 5'h01;
		else if (act)
			cnt_q <= (cnt_q == 5'h10) ? 5'h00 : cnt_q + 5'h01;
	end
	// Kind 0 pulse, 1 first input leads, 2 first input lags
	always_comb begin
		lead = act & ~ph[1];
		lag = act & (ph == 2'h1 || ph == 2'h2);
		c1_out = (kind_in == 2'h2) ? lag : lead;
		c2_out = (kind_in == 2'h0) ? lvl_in : ((kind_in == 2'h2) ? lead : lag);
	end
endmodule : bcd_pulse_model
